// [bench/test_timer0_mode_clock_ctrl.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
// ****************
// Register-level tests.
// ****************
module test_timer0_mode_clock_ctrl;
  import tmc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, take_en = 1'b0;
  logic [7:0]  haddr = 8'h00, q, held;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000, hrdata;
  logic [2:0]  ack;
  logic        hreadyout, hresp, pin, wa, wa_oe, wb, wb_oe, ra, rb, ro, irq;
  int          fail_count = 0, checks = 0, cycles = 0;
  tmc_timer tmc_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_count_pin(pin),
    .ack_cmp_a(ack[2]), .ack_cmp_b(ack[1]), .ack_ovf(ack[0]), .wave_out_a(wa),
    .wave_out_a_oe(wa_oe), .wave_out_b(wb), .wave_out_b_oe(wb_oe), .req_cmp_a(ra),
    .req_cmp_b(rb), .req_ovf(ro), .irq(irq));
  tmc_far_model tmc_far_model_i (.hclk(hclk), .take_en(take_en), .req({ra, rb, ro}),
    .ack(ack), .ext_count_pin(pin));
  initial forever #4 hclk = ~hclk;
  // A hang counts as a mismatch.
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // One single AHB transfer; q takes the low byte of the read data.
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(q, e)
  endtask
  // Rising edges on the count pin, each followed by a fall.
  task automatic edges(input int n);
    repeat (n) begin tmc_far_model_i.drive(1'b1); tmc_far_model_i.drive(1'b0); end
  endtask
  task tally_and_finish;
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(IDX_CMP_B, REG_RESET);
    rd(6'h01, 8'h00);
    xfer(1'b1, IDX_CTRL_A, 8'hFF);
    rd(IDX_CTRL_A, CTRL_A_MASK);
    xfer(1'b1, IDX_MASK, 8'hFF);
    rd(IDX_MASK, MASK_MASK);
    xfer(1'b1, IDX_CTRL_A, 8'h00);
    xfer(1'b1, IDX_CTRL_B, 8'hF0);
    rd(IDX_CTRL_B, 8'h00);
    xfer(1'b1, IDX_COUNT, 8'hA5);
    rd(IDX_COUNT, 8'hA5);
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_DIV1});
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_STOP});
    xfer(1'b0, IDX_COUNT, 8'h00);
    held = q;
    `CHK(held !== 8'hA5, 1'b1)
    rd(IDX_COUNT, held);
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_EXT_RISE});
    xfer(1'b1, IDX_COUNT, 8'hFE);
    xfer(1'b1, IDX_FLAGS, FLAG_MASK);
    edges(2);
    rd(IDX_COUNT, CNT_BOTTOM);
    rd(IDX_FLAGS, 8'h02);
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_EXT_FALL});
    tmc_far_model_i.drive(1'b1);
    rd(IDX_COUNT, 8'h00);
    tmc_far_model_i.drive(1'b0);
    rd(IDX_COUNT, 8'h01);
    xfer(1'b1, IDX_CMP_A, 8'h03);
    xfer(1'b1, IDX_CTRL_A, 8'h42);
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_EXT_RISE});
    xfer(1'b1, IDX_COUNT, 8'h00);
    xfer(1'b1, IDX_FLAGS, FLAG_MASK);
    edges(4);
    rd(IDX_COUNT, 8'h00);
    rd(IDX_FLAGS, 8'h10);
    `CHK(wa, 1'b1)
    `CHK({hresp, wa_oe, wb_oe, wb}, 4'h4)
    edges(1);
    rd(IDX_FLAGS, 8'h18);
    xfer(1'b1, IDX_GLOBAL, 8'h80);
    @(posedge hclk);
    `CHK({ra, rb, ro, irq}, 4'hD)
    xfer(1'b1, IDX_MASK, 8'h08);
    @(posedge hclk);
    `CHK({ra, rb, ro, irq}, 4'h5)
    take_en <= 1'b1;
    repeat (3) @(posedge hclk);
    take_en <= 1'b0;
    `CHK(irq, 1'b0)
    rd(IDX_FLAGS, 8'h10);
    xfer(1'b1, IDX_FLAGS, FLAG_MASK);
    xfer(1'b1, IDX_CTRL_B, 8'h87);
    repeat (2) @(posedge hclk);
    `CHK(wa, 1'b0)
    rd(IDX_FLAGS, 8'h00);
    rd(IDX_COUNT, 8'h01);
    xfer(1'b1, IDX_CTRL_A, 8'h83);
    xfer(1'b1, IDX_CTRL_B, {5'h00, CS_EXT_RISE});
    xfer(1'b1, IDX_COUNT, 8'h10);
    xfer(1'b1, IDX_CMP_B, 8'h11);
    xfer(1'b1, IDX_FLAGS, FLAG_MASK);
    edges(3);
    rd(IDX_FLAGS, 8'h00);
    xfer(1'b1, IDX_COUNT, 8'hFE);
    edges(2);
    rd(IDX_FLAGS, 8'h02);
    rd(IDX_COUNT, CNT_BOTTOM);
    `CHK(wa, 1'b1)
    edges(4);
    `CHK(wa, 1'b0)
    tally_and_finish();
  end
endmodule

// [bench/tmc_far_model.sv]
`timescale 1ns/10ps
// ****************
// Vector taker and count pin.
// ****************
module tmc_far_model
(
  input  wire logic       hclk,          // Clock.
  input  wire logic       take_en,       // Vectors may be taken.
  input  wire logic [2:0] req,           // Requests a, b, ovf.
  output logic      [2:0] ack = 3'h0,    // Vector taken pulses.
  output logic            ext_count_pin = 1'b0 // Count pin.
);
  // Each pending request is taken once, as a one-cycle pulse.
  always @(posedge hclk) ack <= take_en ? (req & ~ack) : 3'h0;
  // Move the pin after an edge and hold it past the synchroniser.
  task automatic drive(input logic v);
    ext_count_pin <= v;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// [bench/tmc_timer_sva.sv]
`timescale 1ns/10ps
// ****************
// Port checks.
// ****************
module tmc_timer_sva
  import tmc_pkg::*;
(
  input wire logic        hclk,      // Clock.
  input wire logic        hresetn,   // Reset.
  input wire logic        hsel,      // Select.
  input wire logic [7:0]  haddr,     // Address.
  input wire logic [1:0]  htrans,    // Type.
  input wire logic        hwrite,    // Write.
  input wire logic        hready,    // Ready in.
  input wire logic        hreadyout, // Ready out.
  input wire logic [31:0] hrdata,    // Read data.
  input wire logic        wave_out_a_oe, // Pin A on.
  input wire logic        req_cmp_a, // Request A.
  input wire logic        req_cmp_b, // Request B.
  input wire logic        req_ovf,   // Request ovf.
  input wire logic        irq        // Interrupt.
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_go; // Read taken.
  logic wr_go; // Write taken.
  assign rd_go = hsel & htrans[1] & hready & !hwrite;
  assign wr_go = hsel & htrans[1] & hready & hwrite;
  a_irq_or: assert property (irq == (req_cmp_a | req_cmp_b | req_ovf))
    else $error("irq mismatch");
  a_read_one_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_no_wait: assert property (wr_go |=> hreadyout)
    else $error("write wait wrong");
  a_upper_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h00_0000)
    else $error("upper lanes set");
  a_ctrl_a_rsvd: assert property (rd_go && haddr == {IDX_CTRL_A, 2'b00} |-> ##2 hrdata[3:2] == 2'h0)
    else $error("ctrl_a reserved set");
  a_ctrl_b_rsvd: assert property (rd_go && haddr == {IDX_CTRL_B, 2'b00} |-> ##2 hrdata[7:4] == 4'h0)
    else $error("ctrl_b force set");
  a_mask_rsvd: assert property (rd_go && haddr == {IDX_MASK, 2'b00} |-> ##2 !hrdata[7] && !hrdata[0])
    else $error("mask reserved set");
  a_oe_by_write: assert property ($changed(wave_out_a_oe) |-> $past(wr_go, 2) && $past(haddr, 2) == {IDX_CTRL_A, 2'b00})
    else $error("oe moved alone");
  c_read: cover property (rd_go ##2 hreadyout);
  c_irq: cover property ($rose(irq));
  c_oe: cover property ($rose(wave_out_a_oe));
endmodule

bind tmc_timer tmc_timer_sva tmc_timer_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .wave_out_a_oe(wave_out_a_oe), .req_cmp_a(req_cmp_a),
  .req_cmp_b(req_cmp_b), .req_ovf(req_ovf), .irq(irq));

// [core/tmc_pkg.sv]
package tmc_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index).
  // ****************************************
  localparam logic [5:0] IDX_CTRL_A  = 6'h2A;  // Waveform mode low bits and output actions.
  localparam logic [5:0] IDX_CMP_A   = 6'h29;  // Compare value A.
  localparam logic [5:0] IDX_CMP_B   = 6'h28;  // Compare value B.
  localparam logic [5:0] IDX_COUNT   = 6'h32;  // Counter value.
  localparam logic [5:0] IDX_CTRL_B  = 6'h33;  // Force strobes, mode high bit, clock select.
  localparam logic [5:0] IDX_FLAGS   = 6'h38;  // Sticky event flags.
  localparam logic [5:0] IDX_MASK    = 6'h39;  // Interrupt enables.
  localparam logic [5:0] IDX_GLOBAL  = 6'h3F;  // Global interrupt enable.

  // ****************************************
  // Field positions and writable-bit masks.
  // ****************************************
  localparam int         FORCE_A_BIT = 7;      // Force compare A strobe in ctrl_b.
  localparam int         FORCE_B_BIT = 6;      // Force compare B strobe in ctrl_b.
  localparam int         WMODE_HI_BIT = 3;     // High waveform mode bit in ctrl_b.
  localparam int         CMP_A_BIT   = 4;      // Compare A enable and flag position.
  localparam int         CMP_B_BIT   = 3;      // Compare B enable and flag position.
  localparam int         OVF_BIT     = 1;      // Overflow enable and flag position.
  localparam int         GIE_BIT     = 7;      // Global enable position.
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;  // Bits 3 and 2 read zero.
  localparam logic [7:0] MASK_MASK   = 8'h7E;  // Bits 7 and 0 read zero.
  localparam logic [7:0] FLAG_MASK   = 8'h1A;  // Only this timer's flags exist.

  // ****************************************
  // Reset values and counter landmarks.
  // ****************************************
  localparam logic [7:0] REG_RESET   = 8'h00;  // Every register clears at reset.
  localparam logic [7:0] CNT_MAX     = 8'hFF;  // MAX.
  localparam logic [7:0] CNT_BOTTOM  = 8'h00;  // BOTTOM.

  // ****************************************
  // Waveform modes and clock selections.
  // ****************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;   // Normal counting.
  localparam logic [2:0] MODE_PC_FF  = 3'h1;   // Phase correct, TOP = MAX.
  localparam logic [2:0] MODE_CTC    = 3'h2;   // Clear on match, TOP = compare A.
  localparam logic [2:0] MODE_FP_FF  = 3'h3;   // Fast PWM, TOP = MAX.
  localparam logic [2:0] MODE_PC_OCR = 3'h5;   // Phase correct, TOP = compare A.
  localparam logic [2:0] MODE_FP_OCR = 3'h7;   // Fast PWM, TOP = compare A.
  localparam logic [2:0] CS_STOP     = 3'h0;   // Counter stopped.
  localparam logic [2:0] CS_DIV1     = 3'h1;   // Undivided clock.
  localparam logic [2:0] CS_DIV8     = 3'h2;   // Clock / 8.
  localparam logic [2:0] CS_DIV64    = 3'h3;   // Clock / 64.
  localparam logic [2:0] CS_DIV256   = 3'h4;   // Clock / 256.
  localparam logic [2:0] CS_DIV1024  = 3'h5;   // Clock / 1024.
  localparam logic [2:0] CS_EXT_FALL = 3'h6;   // External pin, falling edge.
  localparam logic [2:0] CS_EXT_RISE = 3'h7;   // External pin, rising edge.
  localparam int         PRE_BITS    = 10;     // Prescaler bits needed for / 1024.

endpackage

// [core/tmc_timer.sv]
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
// How it works
// RQ1: Reserved bits read zero, writes ignored.
// RQ2: Three mode bits pick counting and TOP.
// RQ3: Compare writes immediate, or buffered in PWM.
// RQ4: Overflow flag point depends on mode.
// RQ5: Force strobe applies action, non-PWM only.
// RQ6: Forced match sets no flag, no clear.
// RQ7: Force bits always read back zero.
// RQ8: Software writes zero forces in PWM.
// RQ9: Clock select picks stop or prescaled clock.
// RQ10: Selects 110/111 count external pin edges.
// RQ11: External pin counts even when output.
// RQ12: Counter is readable and writable.
// RQ13: Counter write blocks next tick's match.
// RQ14: Compare values matched continuously against counter.
// RQ15: Request needs enable, global bit, flag.
// RQ16: Flags set by event, cleared by ack/write-one.
// RQ17: Fast PWM 10 clears on match, sets bottom.
// RQ18: Clear-on-match resets after TOP; normal wraps.
// RQ19: Phase correct up/down; fast PWM restarts zero.
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int PRE_W = PRE_BITS               // Prescaler width.
)(
  input  wire logic        hclk,               // Bus and timer clock.
  input  wire logic        hresetn,            // Asynchronous reset, active low.
  input  wire logic        hsel,               // Slave select.
  input  wire logic [7:0]  haddr,              // Byte address.
  input  wire logic [1:0]  htrans,             // Transfer type.
  input  wire logic        hwrite,             // Write when high.
  input  wire logic [2:0]  hsize,              // Transfer size, word only.
  input  wire logic        hready,             // Bus ready.
  input  wire logic [31:0] hwdata,             // Write data.
  output logic             hreadyout,          // Slave ready.
  output logic [31:0]      hrdata,             // Read data.
  output logic             hresp,              // Response, always OKAY.
  input  wire logic        ext_count_pin,      // External count pin.
  input  wire logic        ack_cmp_a,          // Compare A vector taken.
  input  wire logic        ack_cmp_b,          // Compare B vector taken.
  input  wire logic        ack_ovf,            // Overflow vector taken.
  output logic             wave_out_a,         // Waveform output A.
  output logic             wave_out_a_oe,      // Output A drives its pin.
  output logic             wave_out_b,         // Waveform output B.
  output logic             wave_out_b_oe,      // Output B drives its pin.
  output logic             req_cmp_a,          // Compare A request.
  output logic             req_cmp_b,          // Compare B request.
  output logic             req_ovf,            // Overflow request.
  output logic             irq                 // Any request pending.
);

  // ****************************************
  // Elaboration check.
  // ****************************************
  // The divide-by-1024 tap needs at least ten prescaler bits.
  generate
    if (PRE_W < PRE_BITS)
    begin : g_chk
      $error("PRE_W too small for the slowest prescaler tap");
    end
  endgenerate

  // ****************************************
  // Declarations.
  // ****************************************
  logic             wr_pend;                   // Write data phase pending.
  logic             rd_pend;                   // Read wait state pending.
  logic [5:0]       acc_idx;                   // Index of the pending access.
  logic [7:0]       wdat;                      // Low byte of write data.
  logic [7:0]       ctrl_a;                    // Output actions and low mode bits.
  logic             wave_mode_high;            // High mode bit.
  logic [2:0]       clk_sel;                   // Count source select.
  logic [7:0]       cmp_buf [2];               // Software-visible compare values.
  logic [7:0]       cmp_act [2];               // Compare values in use.
  logic [7:0]       count_value;               // The counter.
  logic             count_up;                  // Direction, phase correct modes.
  logic             blk;                       // Match blocked until next tick.
  logic [7:0]       irq_mask;                  // Interrupt enables.
  logic [7:0]       irq_flags;                 // Sticky flags.
  logic             gie;                       // Global enable.
  logic [PRE_W-1:0] pre;                       // Free-running prescaler.
  logic             ext_s1;                    // Pin synchroniser, first stage.
  logic             ext_s2;                    // Pin synchroniser, second stage.
  logic             ext_d;                     // Delayed synchronised pin.
  logic             tick;                      // Count enable pulse.
  logic [2:0]       mode;                      // Combined waveform mode.
  logic             pwm;                       // Any PWM mode.
  logic             phase;                     // Phase correct mode.
  logic             fast;                      // Fast PWM mode.
  logic [7:0]       top;                       // Current TOP.
  logic [7:0]       next_count;                // Next counter value.
  logic             next_up;                   // Next direction.
  logic             at_top;                    // Counter at TOP.
  logic             ovf_evt;                   // Overflow event this tick.
  logic [1:0]       match;                     // Compare match events.
  logic [1:0]       force_hit;                 // Forced compare strobes.
  logic [1:0]       oc;                        // Waveform output states.
  logic [7:0]       rd_mux;                    // Selected read value.
  logic [7:0]       flag_set;                  // Flag set events.
  logic [7:0]       flag_clr;                  // Flag clear requests.

  // Toggles, clears or sets an output for a non-PWM action code.
  function automatic logic apply_act(input logic [1:0] com, input logic cur);
    case (com)
      2'b01:   apply_act = ~cur;
      2'b10:   apply_act = 1'b0;
      2'b11:   apply_act = 1'b1;
      default: apply_act = cur;
    endcase
  endfunction

  // ****************************************
  // AHB-Lite slave.
  // ****************************************
  // Writes finish with no wait state; reads add one so the data comes from a flop.
  assign hresp     = 1'b0;
  assign hreadyout = ~rd_pend;
  assign wdat      = hwdata[7:0];

  // Captures the address phase of a selected transfer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_idx <= 6'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel & htrans[1] & hwrite;
      rd_pend <= hsel & htrans[1] & ~hwrite;
      acc_idx <= haddr[7:2];
    end
    else
    begin
      // The wait state of a read ends here.
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
    end
  end

  // Builds the read value; unmapped indices read zero.
  always_comb
  begin
    case (acc_idx)
      IDX_CTRL_A: rd_mux = ctrl_a;                                  // [RQ1]
      IDX_CMP_A:  rd_mux = cmp_buf[0];
      IDX_CMP_B:  rd_mux = cmp_buf[1];
      IDX_COUNT:  rd_mux = count_value;                             // [RQ12]
      IDX_CTRL_B: rd_mux = {4'h0, wave_mode_high, clk_sel};         // [RQ7]
      IDX_FLAGS:  rd_mux = irq_flags;
      IDX_MASK:   rd_mux = irq_mask;                                // [RQ1]
      IDX_GLOBAL: rd_mux = {gie, 7'h00};
      default:    rd_mux = 8'h00;
    endcase
  end

  // Registers read data during the wait state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // ****************************************
  // Control registers.
  // ****************************************
  // Holds control, mask and global enable; reserved bits are masked off.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_a         <= REG_RESET;
      wave_mode_high <= 1'b0;
      clk_sel        <= CS_STOP;
      irq_mask       <= REG_RESET;
      gie            <= 1'b0;
    end
    else if (wr_pend)
    begin
      if (acc_idx == IDX_CTRL_A)
      begin
        ctrl_a <= wdat & CTRL_A_MASK;                               // [RQ1]
      end
      if (acc_idx == IDX_CTRL_B)
      begin
        wave_mode_high <= wdat[WMODE_HI_BIT];
        clk_sel        <= wdat[2:0];
      end
      if (acc_idx == IDX_MASK)
      begin
        irq_mask <= wdat & MASK_MASK;                               // [RQ1]
      end
      if (acc_idx == IDX_GLOBAL)
      begin
        gie <= wdat[GIE_BIT];
      end
    end
  end

  // ****************************************
  // Mode decode.
  // ****************************************
  assign mode  = {wave_mode_high, ctrl_a[1:0]};                     // [RQ2]
  assign phase = (mode == MODE_PC_FF) || (mode == MODE_PC_OCR);
  assign fast  = (mode == MODE_FP_FF) || (mode == MODE_FP_OCR);
  assign pwm   = phase | fast;
  // Modes 2, 5 and 7 take TOP from compare A; the rest use MAX.
  assign top   = ((mode == MODE_CTC) || (mode == MODE_PC_OCR) || (mode == MODE_FP_OCR))
                 ? cmp_act[0] : CNT_MAX;                            // [RQ2]
  assign at_top = (count_value == top);

  // ****************************************
  // Clock source.
  // ****************************************
  // Runs the prescaler freely; taps are one-cycle enables.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre <= '0;
    end
    else
    begin
      pre <= pre + 1'b1;
    end
  end

  // Synchronises the pin; only the second stage feeds the edge detector.
  // The pin is watched regardless of its port direction.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d  <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_count_pin;                                      // [RQ11]
      ext_s2 <= ext_s1;
      ext_d  <= ext_s2;
    end
  end

  // Picks the count enable from the clock select.
  always_comb
  begin
    case (clk_sel)                                                  // [RQ9]
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &pre[2:0];
      CS_DIV64:    tick = &pre[5:0];
      CS_DIV256:   tick = &pre[7:0];
      CS_DIV1024:  tick = &pre[9:0];
      CS_EXT_FALL: tick = ext_d & ~ext_s2;                          // [RQ10]
      CS_EXT_RISE: tick = ~ext_d & ext_s2;                          // [RQ10]
      default:     tick = 1'b0;
    endcase
  end

  // ****************************************
  // Counter.
  // ****************************************
  // Works out the next count and direction for the mode.
  always_comb
  begin
    next_up    = 1'b1;
    next_count = count_value + 8'h01;                               // [RQ18]
    if (phase)
    begin
      next_up = count_up;
      if (count_up && at_top)
      begin
        next_up    = 1'b0;
        next_count = (count_value == CNT_BOTTOM) ? CNT_BOTTOM : count_value - 8'h01; // [RQ19]
      end
      else if (!count_up && (count_value == CNT_BOTTOM))
      begin
        next_up    = 1'b1;
        next_count = (top == CNT_BOTTOM) ? CNT_BOTTOM : 8'h01;      // [RQ19]
      end
      else if (!count_up)
      begin
        next_count = count_value - 8'h01;
      end
    end
    else if (((mode == MODE_CTC) || fast) && at_top)
    begin
      next_count = CNT_BOTTOM;                                      // [RQ18] [RQ19]
    end
  end

  // Steps the counter on each tick; a software write wins and blocks a match.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_value <= REG_RESET;
      count_up    <= 1'b1;
      blk         <= 1'b0;
    end
    else if (wr_pend && (acc_idx == IDX_COUNT))
    begin
      count_value <= wdat;                                          // [RQ12]
      blk         <= 1'b1;                                          // [RQ13]
    end
    else if (tick)
    begin
      count_value <= next_count;
      count_up    <= next_up;
      blk         <= 1'b0;                                          // [RQ13]
    end
  end

  // Overflow point: bottom turn, TOP in mode 7, else MAX.
  always_comb
  begin
    if (phase)
    begin
      ovf_evt = tick & ~count_up & (count_value == CNT_BOTTOM);     // [RQ4]
    end
    else if (mode == MODE_FP_OCR)
    begin
      ovf_evt = tick & at_top;                                      // [RQ4]
    end
    else
    begin
      ovf_evt = tick & (count_value == CNT_MAX);                    // [RQ4]
    end
  end

  // ****************************************
  // Compare channels.
  // ****************************************
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
      localparam logic [5:0] IDX = (i == 0) ? IDX_CMP_A : IDX_CMP_B;
      localparam int         FBIT = (i == 0) ? FORCE_A_BIT : FORCE_B_BIT;
      logic       wr_buf;                      // Write to this compare value.
      logic [1:0] com;                         // This channel's action code.
      logic       special;                     // Compare value equals TOP.

      assign wr_buf  = wr_pend & (acc_idx == IDX);
      assign com     = (i == 0) ? ctrl_a[7:6] : ctrl_a[5:4];
      assign special = com[1] & (cmp_act[i] == top);
      // Continuous comparison, gated by the write block.
      assign match[i] = tick & ~blk & (count_value == cmp_act[i]);  // [RQ14] [RQ13]
      // Strobes act in non-PWM modes only and are never stored.
      assign force_hit[i] = wr_pend & (acc_idx == IDX_CTRL_B) & wdat[FBIT] & ~pwm; // [RQ5] [RQ7]

      // Holds the software copy of the compare value.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cmp_buf[i] <= REG_RESET;
        end
        else if (wr_buf)
        begin
          cmp_buf[i] <= wdat;
        end
      end

      // Loads the active value at once in non-PWM modes, or at TOP while counting up in PWM modes.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cmp_act[i] <= REG_RESET;
        end
        else if (!pwm)
        begin
          cmp_act[i] <= wr_buf ? wdat : cmp_buf[i];                 // [RQ3]
        end
        else if (tick && count_up && at_top)
        begin
          cmp_act[i] <= cmp_buf[i];                                 // [RQ3]
        end
      end

      // Drives the waveform state from matches, bottom, TOP and forces.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          oc[i] <= 1'b0;
        end
        else if (force_hit[i])
        begin
          oc[i] <= apply_act(com, oc[i]);                           // [RQ5] [RQ6]
        end
        else if (!pwm)
        begin
          if (match[i])
          begin
            oc[i] <= apply_act(com, oc[i]);                         // [RQ14]
          end
        end
        else if (com[1])
        begin
          if (fast && tick && at_top)
          begin
            oc[i] <= ~com[0];                                       // [RQ17]
          end
          else if (fast && match[i] && !special)
          begin
            oc[i] <= com[0];                                        // [RQ17]
          end
          else if (phase && special && tick && at_top && count_up)
          begin
            oc[i] <= ~com[0];
          end
          else if (phase && match[i] && !special)
          begin
            oc[i] <= count_up ? com[0] : ~com[0];
          end
        end
        else if (com[0] && (i == 0) && wave_mode_high && match[i])
        begin
          oc[i] <= ~oc[i];
        end
      end
    end
  endgenerate

  assign wave_out_a    = oc[0];
  assign wave_out_b    = oc[1];
  assign wave_out_a_oe = |ctrl_a[7:6];
  assign wave_out_b_oe = |ctrl_a[5:4];

  // ****************************************
  // Flags and interrupt requests.
  // ****************************************
  // Forced strobes never reach the flags; setting wins over clearing.
  always_comb
  begin
    flag_set            = 8'h00;
    flag_set[CMP_A_BIT] = match[0];                                 // [RQ6] [RQ16]
    flag_set[CMP_B_BIT] = match[1];
    flag_set[OVF_BIT]   = ovf_evt;
    flag_clr            = (wr_pend && (acc_idx == IDX_FLAGS)) ? wdat : 8'h00;
    flag_clr[CMP_A_BIT] = flag_clr[CMP_A_BIT] | ack_cmp_a;          // [RQ16]
    flag_clr[CMP_B_BIT] = flag_clr[CMP_B_BIT] | ack_cmp_b;
    flag_clr[OVF_BIT]   = flag_clr[OVF_BIT] | ack_ovf;
  end

  // Updates the sticky flags.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_flags <= REG_RESET;
    end
    else
    begin
      irq_flags <= ((irq_flags & ~flag_clr) | flag_set) & FLAG_MASK; // [RQ16]
    end
  end

  assign req_cmp_a = gie & irq_mask[CMP_A_BIT] & irq_flags[CMP_A_BIT]; // [RQ15]
  assign req_cmp_b = gie & irq_mask[CMP_B_BIT] & irq_flags[CMP_B_BIT]; // [RQ15]
  assign req_ovf   = gie & irq_mask[OVF_BIT] & irq_flags[OVF_BIT];     // [RQ15]
  assign irq       = req_cmp_a | req_cmp_b | req_ovf;

endmodule
